// *** inc/ptws_pkg.sv ***
// Constants shared by the trigger waveform generator and its phase timer
package ptws_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_WAVE_CTRL  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PULSE_W    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CYCLE_W    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CNT_PAT    = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_RUN_CTRL   = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CASC_EN_BIT   = 31;
  localparam int CASC_TAIL_BIT = 30;
  localparam int SEL_LSB       = 20;
  localparam int SEL_MSB       = 22;
  localparam int ITER_MSB      = 15;
  localparam int CNT_LSB       = 16;
  localparam int RUN_EN_BIT    = 0;
  localparam int RUN_SRST_BIT  = 1;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  localparam int ST_LEVEL_BIT  = 2;
  localparam int ST_CNT_LSB    = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WAVE_CTRL = 32'h0000_0000;
  localparam logic [15:0] RST_PULSE_W   = 16'h0000;
  localparam logic [31:0] RST_CYCLE_W   = 32'h0000_0000;
  localparam logic [31:0] RST_CNT_PAT   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Waveform selector codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_NEG_EDGE   = 3'h0;
  localparam logic [2:0] SEL_POS_EDGE   = 3'h1;
  localparam logic [2:0] SEL_NEG_PULSE  = 3'h2;
  localparam logic [2:0] SEL_POS_PULSE  = 3'h3;
  localparam logic [2:0] SEL_NEG_PERIOD = 3'h4;
  localparam logic [2:0] SEL_POS_PERIOD = 3'h5;
  localparam logic [2:0] SEL_PATTERN    = 3'h6;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 20;
  localparam int MAX_TOGGLE_KHZ  = 12500;
  localparam int MIN_PHASE_NS    = 1000000 / (2 * MAX_TOGGLE_KHZ);
  localparam int MIN_PHASE_CYC_I = (MIN_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIME_W          = 36;
  localparam logic [TIME_W-1:0] CLK_NS        = TIME_W'(CLK_PERIOD_NS);
  localparam logic [1:0]        MIN_PHASE_CYC = 2'(MIN_PHASE_CYC_I);
  localparam logic [TIME_W-1:0] PW_UNIT_NS    = 36'h0_0000_0008;
  localparam logic [TIME_W-1:0] CW_UNIT_NS    = 36'h0_0000_0001;

  // ----------------------------------------------------------------
  // Generator states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_PH_A  = 5'h02,
    ST_PH_B  = 5'h04,
    ST_SHIFT = 5'h08,
    ST_DONE  = 5'h10
  } ptws_fsm_t;

endpackage : ptws_pkg

// *** inc/ptws_tmr_if.sv ***
// Handshake between the waveform sequencer and its phase timer
`timescale 1ns/100ps
`default_nettype none
interface ptws_tmr_if;
  logic                        start;
  logic [ptws_pkg::TIME_W-1:0] len_ns;
  logic                        done;

  modport ctl (output start, output len_ns, input done);
  modport tmr (input start, input len_ns, output done);
endinterface : ptws_tmr_if
`default_nettype wire

// *** verilog/ptws_timer.sv ***
// Phase timer: measures one output phase in nanoseconds
`timescale 1ns/100ps
`default_nettype none
module ptws_timer (
  input  wire logic aclk,
  input  wire logic aresetn,
  ptws_tmr_if.tmr   tmr
);

  typedef struct packed {
    logic                        run;
    logic [1:0]                  cyc;
    logic [ptws_pkg::TIME_W-1:0] elapsed;
    logic [ptws_pkg::TIME_W-1:0] len;
  } ptws_tmr_state_t;

  ptws_tmr_state_t s_r;
  ptws_tmr_state_t s_nxt;

  // ----------------------------------------------------------------
  // Phase end
  // ----------------------------------------------------------------
  // floor of two cycles
  assign tmr.done = s_r.run && (s_r.elapsed >= s_r.len) &&
                    (s_r.cyc >= ptws_pkg::MIN_PHASE_CYC);

  // Load on start, count until done; a new start always wins
  always_comb begin
    s_nxt = s_r;
    if (tmr.start) begin
      s_nxt.run     = 1'b1;
      s_nxt.cyc     = 2'h1;
      s_nxt.elapsed = ptws_pkg::CLK_NS;
      s_nxt.len     = tmr.len_ns;
    end else if (s_r.run && !tmr.done) begin
      s_nxt.elapsed = s_r.elapsed + ptws_pkg::CLK_NS;
      if (s_r.cyc != 2'h3) begin
        s_nxt.cyc = s_r.cyc + 2'h1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : ptws_timer
`default_nettype wire

// *** verilog/ptws_top.sv ***
// Trigger output waveform generator with AXI4-Lite register slave
//
// Overview of operation
// - Waveform starts only when enabled and target time reached.
// - Code 000: output falls from high idle and stays low.
// - Code 001: positive edge, then output held high.
// - Code 010: low pulse of pulse width from high idle, then high.
// - Code 011: high pulse of pulse width from low idle, then low.
// - Code 100: low phase pulse width, period cycle width, count or forever.
// - Code 101: high phase pulse width, period cycle width, count or forever.
// - Code 110: 16-bit pattern shifted MSB first, looped, bit width each.
// - Pattern stops after total bit count; zero total shifts forever.
// - Output toggle rate never exceeds 12.5 MHz.
// - Cascade tail unit repeats its pattern per 16-bit iteration count.
// - Iterations equal field value plus one.
// - No tail in cascade: repeat forever, iteration count ignored.
// - Pulse width counts in 8 ns units.
// - Cycle or bit width counts in 1 ns units.
// - Untailed cascade loops until the unit is disabled or soft reset.
`timescale 1ns/100ps
`default_nettype none
module ptws_top (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [ptws_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [ptws_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        target_reached,
  output logic                             trig_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]         wave_ctrl;
    logic [15:0]         pulse_w;
    logic [31:0]         cycle_w;
    logic [31:0]         cnt_pat;
    logic                enable;
    ptws_pkg::ptws_fsm_t st;
    logic                out;
    logic [15:0]         evt_cnt;
    logic [15:0]         iter_cnt;
    logic [3:0]          pos;
    logic                bvalid;
    logic [1:0]          bresp;
    logic                rvalid;
    logic [1:0]          rresp;
    logic [31:0]         rdata;
  } ptws_state_t;

  ptws_state_t s_r;
  ptws_state_t s_nxt;

  ptws_tmr_if tmr_if ();

  ptws_timer u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tmr     (tmr_if.tmr)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Byte lane merge for partial writes
  function automatic logic [31:0] ptws_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction : ptws_merge

  function automatic logic ptws_idle_lvl(input logic [2:0] sel);
    return (sel == ptws_pkg::SEL_NEG_EDGE) || (sel == ptws_pkg::SEL_NEG_PULSE) ||
           (sel == ptws_pkg::SEL_NEG_PERIOD);
  endfunction : ptws_idle_lvl

  // ----------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------
  logic [2:0]                  sel;
  logic                        casc_en;
  logic                        casc_tail;
  logic [15:0]                 iter_max;
  logic [15:0]                 count;
  logic [15:0]                 pattern;
  logic [ptws_pkg::TIME_W-1:0] pw_ns;
  logic [ptws_pkg::TIME_W-1:0] cw_ns;
  logic [ptws_pkg::TIME_W-1:0] rest_ns;
  logic                        wr_go;
  logic                        rd_go;
  logic                        last_bit;
  logic                        pat_end;

  assign sel       = s_r.wave_ctrl[ptws_pkg::SEL_MSB:ptws_pkg::SEL_LSB];
  assign casc_en   = s_r.wave_ctrl[ptws_pkg::CASC_EN_BIT];
  assign casc_tail = s_r.wave_ctrl[ptws_pkg::CASC_TAIL_BIT];
  assign iter_max  = s_r.wave_ctrl[ptws_pkg::ITER_MSB:0];
  assign count     = s_r.cnt_pat[31:ptws_pkg::CNT_LSB];
  assign pattern   = s_r.cnt_pat[15:0];

  // pulse width in 8 ns units
  assign pw_ns   = ptws_pkg::TIME_W'(s_r.pulse_w) * ptws_pkg::PW_UNIT_NS;
  // cycle or bit width in 1 ns units
  assign cw_ns   = ptws_pkg::TIME_W'(s_r.cycle_w) * ptws_pkg::CW_UNIT_NS;
  // Second phase takes what the pulse leaves of the period
  assign rest_ns = (cw_ns > pw_ns) ? (cw_ns - pw_ns) : '0;

  // Pattern bookkeeping: pos names the next bit, so 15 means bit 0 just ended
  assign last_bit = (s_r.pos == 4'hf);
  always_comb begin
    if (casc_en) begin
      // tail stops after field plus one passes
      pat_end = casc_tail && last_bit && (s_r.iter_cnt == iter_max);
    end else begin
      // total bit count, zero is endless
      pat_end = (count != 16'h0000) && ((s_r.evt_cnt + 16'h0001) == count);
    end
  end

  // AXI: address and data are taken together, one transfer outstanding
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !s_r.bvalid;
  assign rd_go         = s_axi_arvalid && !s_r.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = s_r.rdata;
  assign trig_out      = s_r.out;

  // ----------------------------------------------------------------
  // Register access and waveform sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic srst;
    srst             = 1'b0;
    s_nxt            = s_r;
    tmr_if.start     = 1'b0;
    tmr_if.len_ns    = '0;

    // Response handshakes retire first
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // Register writes
    if (wr_go) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = ptws_pkg::RESP_OKAY;
      case (s_axi_awaddr)
        ptws_pkg::OFS_WAVE_CTRL: begin
          // Reserved 29:23 and 19:16 stay zero
          s_nxt.wave_ctrl = ptws_merge(s_r.wave_ctrl, s_axi_wdata, s_axi_wstrb) &
                            32'hc070_ffff;
        end
        ptws_pkg::OFS_PULSE_W: begin
          s_nxt.pulse_w = 16'(ptws_merge({16'h0000, s_r.pulse_w}, s_axi_wdata, s_axi_wstrb));
        end
        ptws_pkg::OFS_CYCLE_W: begin
          s_nxt.cycle_w = ptws_merge(s_r.cycle_w, s_axi_wdata, s_axi_wstrb);
        end
        ptws_pkg::OFS_CNT_PAT: begin
          s_nxt.cnt_pat = ptws_merge(s_r.cnt_pat, s_axi_wdata, s_axi_wstrb);
        end
        ptws_pkg::OFS_RUN_CTRL: begin
          if (s_axi_wstrb[0]) begin
            s_nxt.enable = s_axi_wdata[ptws_pkg::RUN_EN_BIT];
            srst         = s_axi_wdata[ptws_pkg::RUN_SRST_BIT];
          end
        end
        ptws_pkg::OFS_STATUS: begin
          // Read-only; write is accepted and ignored
        end
        default: begin
          s_nxt.bresp = ptws_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Register reads
    if (rd_go) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = ptws_pkg::RESP_OKAY;
      case (s_axi_araddr)
        ptws_pkg::OFS_WAVE_CTRL: s_nxt.rdata = s_r.wave_ctrl;
        ptws_pkg::OFS_PULSE_W:   s_nxt.rdata = {16'h0000, s_r.pulse_w};
        ptws_pkg::OFS_CYCLE_W:   s_nxt.rdata = s_r.cycle_w;
        ptws_pkg::OFS_CNT_PAT:   s_nxt.rdata = s_r.cnt_pat;
        ptws_pkg::OFS_RUN_CTRL:  s_nxt.rdata = {31'h0000_0000, s_r.enable};
        ptws_pkg::OFS_STATUS: begin
          s_nxt.rdata = '0;
          s_nxt.rdata[ptws_pkg::ST_BUSY_BIT]  = (s_r.st != ptws_pkg::ST_IDLE) &&
                                                (s_r.st != ptws_pkg::ST_DONE);
          s_nxt.rdata[ptws_pkg::ST_DONE_BIT]  = (s_r.st == ptws_pkg::ST_DONE);
          s_nxt.rdata[ptws_pkg::ST_LEVEL_BIT] = s_r.out;
          s_nxt.rdata[31:ptws_pkg::ST_CNT_LSB] = s_r.evt_cnt;
        end
        default: begin
          s_nxt.rdata = '0;
          s_nxt.rresp = ptws_pkg::RESP_SLVERR;
        end
      endcase
    end

    // Sequencer
    case (s_r.st)
      ptws_pkg::ST_IDLE: begin
        s_nxt.out      = ptws_idle_lvl(sel);
        s_nxt.evt_cnt  = '0;
        s_nxt.iter_cnt = '0;
        // fire on enable and time reached
        if (s_r.enable && target_reached) begin
          case (sel)
            ptws_pkg::SEL_NEG_EDGE: begin
              s_nxt.out = 1'b0;
              s_nxt.st  = ptws_pkg::ST_DONE;
            end
            ptws_pkg::SEL_POS_EDGE: begin
              s_nxt.out = 1'b1;
              s_nxt.st  = ptws_pkg::ST_DONE;
            end
            ptws_pkg::SEL_NEG_PULSE, ptws_pkg::SEL_POS_PULSE,
            ptws_pkg::SEL_NEG_PERIOD, ptws_pkg::SEL_POS_PERIOD: begin
              s_nxt.out     = !ptws_idle_lvl(sel);
              s_nxt.st      = ptws_pkg::ST_PH_A;
              tmr_if.start  = 1'b1;
              tmr_if.len_ns = pw_ns;
            end
            ptws_pkg::SEL_PATTERN: begin
              s_nxt.out     = pattern[15];
              s_nxt.pos     = 4'he;
              s_nxt.st      = ptws_pkg::ST_SHIFT;
              tmr_if.start  = 1'b1;
              tmr_if.len_ns = cw_ns;
            end
            default: begin
              // Reserved code never fires; software keeps it out
            end
          endcase
        end
      end
      ptws_pkg::ST_PH_A: begin
        if (tmr_if.done) begin
          s_nxt.out = !s_r.out;
          if ((sel == ptws_pkg::SEL_NEG_PULSE) || (sel == ptws_pkg::SEL_POS_PULSE)) begin
            // single pulse ends at idle level
            s_nxt.st = ptws_pkg::ST_DONE;
          end else begin
            s_nxt.st      = ptws_pkg::ST_PH_B;
            tmr_if.start  = 1'b1;
            tmr_if.len_ns = rest_ns;
          end
        end
      end
      ptws_pkg::ST_PH_B: begin
        if (tmr_if.done) begin
          s_nxt.evt_cnt = s_r.evt_cnt + 16'h0001;
          // stop at cycle count, zero runs forever
          if ((count != 16'h0000) && ((s_r.evt_cnt + 16'h0001) == count)) begin
            s_nxt.st = ptws_pkg::ST_DONE;
          end else begin
            s_nxt.out     = !s_r.out;
            s_nxt.st      = ptws_pkg::ST_PH_A;
            tmr_if.start  = 1'b1;
            tmr_if.len_ns = pw_ns;
          end
        end
      end
      ptws_pkg::ST_SHIFT: begin
        if (tmr_if.done) begin
          s_nxt.evt_cnt = s_r.evt_cnt + 16'h0001;
          if (last_bit) begin
            s_nxt.iter_cnt = s_r.iter_cnt + 16'h0001;
          end
          if (pat_end) begin
            // Finished pattern rests at the low level
            s_nxt.out = 1'b0;
            s_nxt.st  = ptws_pkg::ST_DONE;
          end else begin
            s_nxt.out     = pattern[s_r.pos];
            s_nxt.pos     = s_r.pos - 4'h1;
            tmr_if.start  = 1'b1;
            tmr_if.len_ns = cw_ns;
          end
        end
      end
      ptws_pkg::ST_DONE: begin
        // Final level holds until software disables the unit
      end
      default: begin
        s_nxt.st = ptws_pkg::ST_IDLE;
      end
    endcase

    // Disable or soft reset aborts any waveform
    // soft reset ends an endless loop
    // a cut phase keeps its level one more cycle, so no runt appears
    if (srst || !s_nxt.enable) begin
      s_nxt.st  = ptws_pkg::ST_IDLE;
      s_nxt.out = (s_r.st == ptws_pkg::ST_IDLE) ? ptws_idle_lvl(sel) : s_r.out;
    end
    if (srst) begin
      s_nxt.enable = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r           <= '0;
      s_r.wave_ctrl <= ptws_pkg::RST_WAVE_CTRL;
      s_r.pulse_w   <= ptws_pkg::RST_PULSE_W;
      s_r.cycle_w   <= ptws_pkg::RST_CYCLE_W;
      s_r.cnt_pat   <= ptws_pkg::RST_CNT_PAT;
      s_r.st        <= ptws_pkg::ST_IDLE;
      s_r.out       <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : ptws_top
`default_nettype wire

// *** verif/ptws_sampler.sv ***
// Far-side equipment that samples the trigger pin once per clock
`timescale 1ns/100ps
`default_nettype none
module ptws_sampler (
  input wire logic aclk,
  input wire logic rec,
  input wire logic trig_out
);
  logic lvl_q[$];
  // One sample per rising edge while armed; the bench reads the queue
  always @(posedge aclk) begin
    if (rec) lvl_q.push_back(trig_out);
  end
endmodule : ptws_sampler
`default_nettype wire

// *** verif/ptws_top_props.sv ***
// Concurrent checks on the generator's register bus and trigger pin
`timescale 1ns/100ps
`default_nettype none
module ptws_top_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        trig_out
);
  // ----------------------------------------
  // Handshakes and pin timing
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_aw_accept: assert property (s_axi_awready ==
    (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid)) else $error("awready wrong");
  chk_b_follows: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("no write response");
  chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_ar_accept: assert property (s_axi_arready == (s_axi_arvalid && !s_axi_rvalid))
    else $error("arready wrong");
  chk_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read response");
  chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_reset_idle: assert property ($rose(aresetn) |-> trig_out)
    else $error("pin not high after reset");
  // Two-cycle floor keeps the pin under the toggle limit, aborts included
  chk_min_phase: assert property ($changed(trig_out) |=>
    $stable(trig_out)) else $error("phase too short");
endmodule : ptws_top_props

bind ptws_top ptws_top_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .trig_out(trig_out));
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench: register bus and per-cycle waveform model
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, b); end end
module tb_top;
  logic       aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tgt, rec, trig_out;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v;
  logic [1:0] bresp, rresp, r;
  logic       awready, wready, bvalid, arready, rvalid;
  int         errors, samples_checked, cyc, seed, s, pw, cw;
  logic       exq[$];

  ptws_top u_ptws_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .target_reached(tgt), .trig_out(trig_out));
  ptws_sampler u_ptws_sampler (.aclk(aclk), .rec(rec), .trig_out(trig_out));

  // Free-running clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Hang guard, well above the planned run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin errors++; finish_test(); end
  end

  task finish_test();
    $display("Samples checked %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test

  // Ready and valid are read at the taking edge, before that edge's updates land
  task wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] rs);
    @(posedge aclk); awaddr <= a; wdata <= dat; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk); while (!awready) @(posedge aclk);
    awvalid <= 1'b0; wvalid <= 1'b0;
    @(posedge aclk); while (!bvalid) @(posedge aclk);
    rs = bresp; bready <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] rs);
    @(posedge aclk); araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    @(posedge aclk); while (!arready) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk); while (!rvalid) @(posedge aclk);
    dat = rdata; rs = rresp; rready <= 1'b0;
  endtask : rd

  // Cycles per phase: 20 ns clock with a two-cycle floor
  function int cy(input int ns);
    return (ns <= 40) ? 2 : (ns + 19) / 20;
  endfunction : cy

  task put(input logic lv, input int n);
    repeat (n) exq.push_back(lv);
  endtask : put

  // One firing: model builds the expected pin level for every cycle
  task run(input logic [2:0] sel, input logic [1:0] cm, input int cnt, it, lim);
    logic idle;
    int   k, i;
    begin
      idle = (sel == 3'h0 || sel == 3'h2 || sel == 3'h4);
      k = (cm == 2'b11) ? 16 * (it + 1) : (cm == 2'b10 || cnt == 0) ? lim : cnt;
      exq.delete();
      u_ptws_sampler.lvl_q.delete();
      wr(8'h00, {cm, 7'h00, sel, 4'h0, 16'(it)}, r);
      wr(8'h04, 32'(pw), r);
      wr(8'h08, 32'(cw), r);
      wr(8'h0c, {16'(cnt), v[15:0]}, r);
      wr(8'h14, 32'h1, r);
      put(idle, 4);
      if (sel < 3'h2) put(!idle, 6);
      else if (sel < 3'h4) begin put(!idle, cy(pw * 8)); put(idle, 6); end
      else if (sel < 3'h6) begin
        repeat (k) begin put(!idle, cy(pw * 8)); put(idle, cy(cw - pw * 8)); end
        if (k != lim) put(idle, 6);
      end else begin
        for (i = 0; i < k; i++) put(v[15 - i % 16], cy(cw));
        if (k != lim) put(1'b0, 6);
      end
      @(posedge aclk); rec <= 1'b1;
      repeat (3) @(posedge aclk);
      tgt <= 1'b1;
      while (u_ptws_sampler.lvl_q.size() < exq.size()) @(posedge aclk);
      rec <= 1'b0;
      foreach (exq[i]) `CHK(u_ptws_sampler.lvl_q[i], exq[i])
      rd(8'h10, d, r);
      `CHK(d[1:0], (k == lim) ? 2'b01 : 2'b10)
      tgt <= 1'b0;
      wr(8'h14, (k == lim) ? 32'h2 : 32'h0, r);
      repeat (2) @(posedge aclk);
      `CHK(trig_out, idle)
    end
  endtask : run

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tgt, rec} = '0;
    {awaddr, araddr, wdata} = '0;
    seed = 66887;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (s = 0; s < 16; s += 4) begin rd(8'(s), d, r); `CHK(d, 32'h0) end
    rd(8'h20, d, r);
    `CHK({r, d}, {ptws_pkg::RESP_SLVERR, 32'h0})
    wr(8'h20, 32'h1, r);
    `CHK(r, ptws_pkg::RESP_SLVERR)
    // selector 111 never programmed; reserved bits kept clear
    v = $random(seed) & 32'hc030ffff;
    wr(8'h00, v, r);
    rd(8'h00, d, r);
    `CHK(d, v)
    for (s = 0; s < 11; s++) begin
      v = $random(seed);
      pw = 3 + v[19:16] % 10;
      cw = pw * 8 + 20 + v[27:20] % 60;
      if (s < 7) run(3'(s), 2'b00, (s == 6) ? 20 : 3, 0, 0);
      else if (s == 7) run(3'h5, 2'b00, 0, 0, 5);
      else run(3'h6, (s == 10) ? 2'b10 : 2'b11, 0, s - 8, 40);
    end
    finish_test();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire
